/* rtl/sse_core.sv */
// four-phase execution of the two subtracts and the nibble swap, apb slave
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sse_regs.svh"

module sse_core (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             busy
);
	import sse_pkg::*;

	// ==========================================================
	// state
	sse_phase_t  phase;
	sse_op_t     op;
	logic [13:0] instr;
	logic [7:0]  acc;
	logic [7:0]  mem [0:127];
	logic [6:0]  faddr;
	logic [6:0]  op_addr;
	logic        op_dest;
	logic [7:0]  op_lit;
	logic [7:0]  operand;
	logic [7:0]  res_q;
	logic        res_c;
	logic        res_dc;
	logic        res_z;
	logic        flag_c;
	logic        flag_dc;
	logic        flag_z;

	// ==========================================================
	// apb decode
	wire        setup_ph   = psel & ~penable;
	wire        access_ph  = psel & penable;
	wire        sel_instr  = (paddr == `SSE_OFF_INSTR);
	wire        sel_acc    = (paddr == `SSE_OFF_ACC);
	wire        sel_status = (paddr == `SSE_OFF_STATUS);
	wire        sel_faddr  = (paddr == `SSE_OFF_FADDR);
	wire        sel_fdata  = (paddr == `SSE_OFF_FDATA);
	wire        mapped     = sel_instr | sel_acc | sel_status | sel_faddr | sel_fdata;
	wire        is_busy    = (phase != PH_IDLE);
	// writes that would disturb a running instruction are refused
	wire        wr_locked  = is_busy & (sel_instr | sel_acc | sel_status | sel_fdata);
	wire        wr_ok      = clk_en & access_ph & pwrite & mapped & ~wr_locked;
	wire        start      = wr_ok & sel_instr;
	wire        acc_wr_bus = wr_ok & sel_acc;
	wire        st_wr_bus  = wr_ok & sel_status;
	wire        fa_wr_bus  = wr_ok & sel_faddr;
	wire        fd_wr_bus  = wr_ok & sel_fdata;

	wire [31:0] status_rd  = {28'h0000000, is_busy, flag_z, flag_dc, flag_c};
	wire [31:0] rd_mux     = sel_instr  ? {18'h00000, instr} :
	                         sel_acc    ? {24'h000000, acc} :
	                         sel_status ? status_rd :
	                         sel_faddr  ? {25'h0000000, faddr} :
	                         sel_fdata  ? {24'h000000, mem[faddr]} : 32'h00000000;

	assign pready  = clk_en;
	assign pslverr = access_ph & (~mapped | (pwrite & wr_locked));
	assign busy    = is_busy;

	// ==========================================================
	// decode of the latched instruction word
	wire        dec_sub_reg = (instr[13:8] == `SSE_OPC_SUB_REG);
	wire        dec_swap    = (instr[13:8] == `SSE_OPC_SWAP);
	wire        dec_sub_lit = (instr[13:9] == `SSE_OPC_SUB_LIT);
	wire sse_op_t next_op   = sse_op_t'(dec_sub_lit ? OP_SUB_LIT :
	                                    dec_sub_reg ? OP_SUB_REG :
	                                    dec_swap    ? OP_SWAP : OP_NONE);

	wire        is_sub      = (op == OP_SUB_REG) | (op == OP_SUB_LIT);
	wire        to_acc      = (op == OP_SUB_LIT) | ((op != OP_NONE) & ~op_dest);
	wire        to_mem      = ((op == OP_SUB_REG) | (op == OP_SWAP)) & op_dest;
	wire [7:0]  next_operand = (op == OP_SUB_LIT) ? op_lit : mem[op_addr];

	wire [7:0]  alu_res;
	wire        alu_c;
	wire        alu_dc;
	wire        alu_z;

	sse_alu u_alu (
		.op      (op),
		.operand (operand),
		.acc     (acc),
		.result  (alu_res),
		.carry   (alu_c),
		.dcarry  (alu_dc),
		.zero    (alu_z)
	);

	// ==========================================================
	// phase sequencer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			phase <= PH_IDLE;
		end else if (clk_en) begin
			unique case (phase)
				PH_IDLE:   if (start) phase <= PH_DECODE;
				PH_DECODE: phase <= PH_READ;
				PH_READ:   phase <= PH_PROC;
				PH_PROC:   phase <= PH_WRITE;
				PH_WRITE:  phase <= PH_IDLE;
				default:   phase <= PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// instruction word and file pointer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			instr <= `SSE_RST_INSTR;
			faddr <= `SSE_RST_FADDR;
		end else if (clk_en) begin
			if (start)
				instr <= pwdata[13:0];
			if (fa_wr_bus)
				faddr <= pwdata[6:0];
		end
	end

	// ==========================================================
	// decode, read and process latches
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			op      <= OP_NONE;
			op_addr <= 7'h00;
			op_dest <= 1'b0;
			op_lit  <= 8'h00;
			operand <= 8'h00;
			res_q   <= 8'h00;
			res_c   <= 1'b0;
			res_dc  <= 1'b0;
			res_z   <= 1'b0;
		end else if (clk_en) begin
			if (phase == PH_DECODE) begin
				op      <= next_op;
				op_addr <= instr[6:0];
				op_dest <= instr[7];
				op_lit  <= instr[7:0];
			end
			if (phase == PH_READ)
				operand <= next_operand;
			if (phase == PH_PROC) begin
				res_q  <= alu_res;
				res_c  <= alu_c;
				res_dc <= alu_dc;
				res_z  <= alu_z;
			end
		end
	end

	// ==========================================================
	// write phase: accumulator, register file and flags
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			acc     <= `SSE_RST_ACC;
			{flag_z, flag_dc, flag_c} <= `SSE_RST_FLAGS;
		end else if (clk_en) begin
			if (phase == PH_WRITE && to_acc)
				acc <= res_q;
			else if (acc_wr_bus)
				acc <= pwdata[7:0];
			if (phase == PH_WRITE && is_sub) begin
				flag_c  <= res_c;
				flag_dc <= res_dc;
				flag_z  <= res_z;
			end else if (st_wr_bus) begin
				flag_c  <= pwdata[`SSE_ST_CARRY];
				flag_dc <= pwdata[`SSE_ST_DCARRY];
				flag_z  <= pwdata[`SSE_ST_ZERO];
			end
		end
	end

	// register file has no reset; software loads it before use
	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			if (phase == PH_WRITE && to_mem)
				mem[op_addr] <= res_q;
			else if (fd_wr_bus)
				mem[faddr] <= pwdata[7:0];
		end
	end

	// read data is captured in the setup phase
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			prdata <= 32'h00000000;
		else if (clk_en && setup_ph)
			prdata <= rd_mux;
	end

	// ==========================================================
	// assertions
	wire w_write = (phase == PH_WRITE) & clk_en;

	sequence s_decode_to_proc;
		(phase == PH_DECODE && clk_en) ##1 (phase == PH_READ && clk_en)
			##1 (phase == PH_PROC && clk_en);
	endsequence

	sequence s_write_sub_reg_acc;
		w_write && op == OP_SUB_REG && !op_dest;
	endsequence

	property p_sub_reg_result;
		@(posedge ref_clk) disable iff (sys_rst)
		(phase == PH_PROC && clk_en && op == OP_SUB_REG) ##1 s_write_sub_reg_acc
			|=> acc == $past(operand, 2) - $past(acc, 2);
	endproperty
	a_sub_reg_result: assert property (p_sub_reg_result)
		else $error("subtract from register gave wrong accumulator");

	property p_carry;
		@(posedge ref_clk) disable iff (sys_rst)
		(w_write && is_sub) |=> flag_c == ($past(operand) >= $past(acc));
	endproperty
	a_carry: assert property (p_carry)
		else $error("carry flag does not match borrow");

	property p_four_phase;
		@(posedge ref_clk) disable iff (sys_rst)
		s_decode_to_proc |=> (phase == PH_WRITE);
	endproperty
	a_four_phase: assert property (p_four_phase)
		else $error("phase order broken");

	property p_swap_flags;
		@(posedge ref_clk) disable iff (sys_rst)
		(w_write && op == OP_SWAP) |=> $stable({flag_c, flag_dc, flag_z})
			&& $past(res_q) == {$past(operand[3:0]), $past(operand[7:4])};
	endproperty
	a_swap_flags: assert property (p_swap_flags)
		else $error("swap changed flags or gave wrong result");

	property p_swap_dest;
		@(posedge ref_clk) disable iff (sys_rst)
		(w_write && op == OP_SWAP && op_dest) |=> mem[$past(op_addr)] == $past(res_q)
			&& $stable(acc);
	endproperty
	a_swap_dest: assert property (p_swap_dest)
		else $error("swap to register went to wrong place");

	property p_decode_fields;
		@(posedge ref_clk) disable iff (sys_rst)
		(phase == PH_DECODE && clk_en) |=> op_addr == $past(instr[6:0])
			&& op_dest == $past(instr[7]);
	endproperty
	a_decode_fields: assert property (p_decode_fields)
		else $error("address or destination not decoded");

	property p_lit_result;
		@(posedge ref_clk) disable iff (sys_rst)
		(w_write && op == OP_SUB_LIT) |=> acc == $past(op_lit) - $past(acc);
	endproperty
	a_lit_result: assert property (p_lit_result)
		else $error("literal subtract gave wrong accumulator");

	property p_lit_decode;
		@(posedge ref_clk) disable iff (sys_rst)
		(phase == PH_DECODE && clk_en && instr[13:9] == 5'h1E)
			|=> op == OP_SUB_LIT && op_lit == $past(instr[7:0]);
	endproperty
	a_lit_decode: assert property (p_lit_decode)
		else $error("literal subtract not recognised");

	property p_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		(w_write && is_sub) |=> flag_z == ($past(operand) == $past(acc));
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag wrong after subtract");

endmodule
`default_nettype wire

/* pkg/sse_regs.svh */
// register offsets, field positions, reset values and opcode patterns
// Functional notes
// - register-minus-accumulator subtract writes f minus W to the chosen destination
// - subtracts set carry when no borrow, clear it when result negative
// - literal subtract runs decode, read, process, write over four phases
// - swap exchanges operand nibbles and leaves every status flag unchanged
// - swap destination bit 0 writes accumulator, 1 writes the addressed register
// - register instructions carry a 7-bit address 0..127 and one destination bit
// - literal subtract writes the 8-bit literal minus W into the accumulator
// - literal subtract is recognised by top bits 11110, one don't-care, 8-bit literal
`ifndef SSE_REGS_SVH
`define SSE_REGS_SVH

// ==========================================================
// apb register offsets (byte addresses)
`define SSE_OFF_INSTR    8'h00
`define SSE_OFF_ACC      8'h04
`define SSE_OFF_STATUS   8'h08
`define SSE_OFF_FADDR    8'h0C
`define SSE_OFF_FDATA    8'h10

// ==========================================================
// status field positions
`define SSE_ST_CARRY     0
`define SSE_ST_DCARRY    1
`define SSE_ST_ZERO      2
`define SSE_ST_BUSY      3

// ==========================================================
// reset values
`define SSE_RST_ACC      8'h00
`define SSE_RST_FLAGS    3'h0
`define SSE_RST_INSTR    14'h0000
`define SSE_RST_FADDR    7'h00

// ==========================================================
// opcode patterns
`define SSE_OPC_SUB_REG  6'h02
`define SSE_OPC_SWAP     6'h0E
`define SSE_OPC_SUB_LIT  5'h1E

`endif

/* pkg/sse_pkg.sv */
// types shared by the subtract and swap execution datapath
package sse_pkg;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_SUB_REG,
		OP_SUB_LIT,
		OP_SWAP
	} sse_op_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_DECODE,
		PH_READ,
		PH_PROC,
		PH_WRITE
	} sse_phase_t;

endpackage

/* rtl/sse_alu.sv */
// arithmetic and nibble swap for the execution datapath
`timescale 1ns/100ps
`default_nettype none

module sse_alu (
	input  wire sse_pkg::sse_op_t op,
	input  wire logic [7:0]       operand,
	input  wire logic [7:0]       acc,
	output logic      [7:0]       result,
	output logic                  carry,
	output logic                  dcarry,
	output logic                  zero
);
	import sse_pkg::*;

	wire [8:0] diff_full = {1'b0, operand} - {1'b0, acc};
	wire [4:0] diff_low  = {1'b0, operand[3:0]} - {1'b0, acc[3:0]};
	wire       is_swap   = (op == OP_SWAP);

	assign result = is_swap ? {operand[3:0], operand[7:4]} : diff_full[7:0];
	assign carry  = ~diff_full[8];
	assign dcarry = ~diff_low[4];
	assign zero   = (diff_full[7:0] == 8'h00);

endmodule
`default_nettype wire

/* tb/tb_sse_core.sv */
// self-checking testbench for the subtract and swap execution datapath
`timescale 1ns/100ps
`default_nettype none
`include "sse_regs.svh"

module tb_sse_core;
	import sse_pkg::*;

	// ==========================================================
	// signals
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clk_en  = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic [31:0] rd;
	logic        err;
	int          failures = 0;
	int          num_checks = 0;
	logic [7:0]  fa[4] = '{8'h03, 8'h02, 8'h01, 8'h10};
	logic [7:0]  wa[4] = '{8'h02, 8'h02, 8'h02, 8'h01};
	logic [6:0]  aa[4] = '{7'h05, 7'h7F, 7'h00, 7'h40};
	logic        da[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	always #5 ref_clk = ~ref_clk;

	sse_core i_dut (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.busy    (busy)
	);

	// ==========================================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// one apb transfer: setup, then access until pready at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask

	task setf(input logic [6:0] a, input logic [7:0] v);
		apb(1'b1, `SSE_OFF_FADDR, {25'h0, a});
		apb(1'b1, `SSE_OFF_FDATA, {24'h0, v});
	endtask

	// expected {zero, digit carry, carry} of a minus b
	function automatic logic [2:0] st(input logic [7:0] a, input logic [7:0] b);
		return {a == b, a[3:0] >= b[3:0], a >= b};
	endfunction

	// start an instruction and count enabled-or-stalled cycles of busy
	task exec(input logic [13:0] ins, input int stall);
		int n;
		apb(1'b1, `SSE_OFF_INSTR, {18'h0, ins});
		#1;
		chk({31'h0, busy}, 32'h1, "busy at start");
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			@(posedge ref_clk);
			clk_en <= (n < stall) ? 1'b0 : 1'b1;
			n++;
			#1;
			if (n <= stall)
				chk({31'h0, pready}, 32'h0, "pready while frozen");
		end
		chk(32'(n), 32'(4 + stall), "phase count");
	endtask

	// ==========================================================
	// tests
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc(`SSE_OFF_ACC, 32'h0, "acc reset");
		rdc(`SSE_OFF_STATUS, 32'h0, "status reset");
		for (int i = 0; i < 4; i++) begin
			setf(aa[i], fa[i]);
			apb(1'b1, `SSE_OFF_ACC, {24'h0, wa[i]});
			exec({`SSE_OPC_SUB_REG, da[i], aa[i]}, (i == 1) ? 3 : 0);
			rdc(`SSE_OFF_ACC, {24'h0, da[i] ? wa[i] : 8'(fa[i] - wa[i])}, "sub acc");
			apb(1'b1, `SSE_OFF_FADDR, {25'h0, aa[i]});
			rdc(`SSE_OFF_FDATA, {24'h0, da[i] ? 8'(fa[i] - wa[i]) : fa[i]}, "sub reg");
			rdc(`SSE_OFF_STATUS, {29'h0, st(fa[i], wa[i])}, "sub flags");
		end
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `SSE_OFF_ACC, 32'(i + 1));
			exec({`SSE_OPC_SUB_LIT, 1'(i), 8'h02}, 0);
			rdc(`SSE_OFF_ACC, {24'h0, 8'(8'h02 - 8'(i + 1))}, "lit acc");
			rdc(`SSE_OFF_STATUS, {29'h0, st(8'h02, 8'(i + 1))}, "lit flags");
		end
		setf(7'h7F, 8'hA5);
		apb(1'b1, `SSE_OFF_STATUS, 32'h5);
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, `SSE_OFF_ACC, 32'h33);
			exec({`SSE_OPC_SWAP, 1'(d), 7'h7F}, 0);
			rdc(`SSE_OFF_ACC, (d == 0) ? 32'h5A : 32'h33, "swap acc");
			rdc(`SSE_OFF_FDATA, (d == 0) ? 32'hA5 : 32'h5A, "swap reg");
			rdc(`SSE_OFF_STATUS, 32'h5, "swap flags");
		end
		// an unknown opcode runs its phases and changes nothing
		exec(14'h0000, 0);
		rdc(`SSE_OFF_ACC, 32'h33, "unknown op acc");
		rdc(`SSE_OFF_FDATA, 32'h5A, "unknown op reg");
		rdc(`SSE_OFF_STATUS, 32'h5, "unknown op flags");
		// a write during execution is refused and does not disturb the result
		apb(1'b1, `SSE_OFF_ACC, 32'h1);
		apb(1'b1, `SSE_OFF_INSTR, {18'h0, `SSE_OPC_SUB_LIT, 1'b0, 8'h10});
		apb(1'b1, `SSE_OFF_ACC, 32'h77);
		chk({31'h0, err}, 32'h1, "busy write refused");
		repeat (10) @(posedge ref_clk);
		rdc(`SSE_OFF_ACC, 32'h0F, "acc after refusal");
		rdc(8'h14, 32'h0, "unmapped read");
		chk({31'h0, err}, 32'h1, "unmapped read error");
		apb(1'b1, 8'h1C, 32'hFF);
		chk({31'h0, err}, 32'h1, "unmapped write error");
		conclude;
	end

	// ==========================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		conclude;
	end
endmodule
`default_nettype wire
